// ### hw/scl_pkg.sv
// Notes on behaviour
// RL1: Bit 7 of register five set turns adaptive dead time off.
// RL2: Software writes zero into all reserved bits of both registers.
// RL3: Writes to register six are dropped unless the unlock bit is one.
// RL4: Software sets unlock before writing register six, then clears it.
// RL5: Selector codes route monitor pin: ground, supply, temp, reference, amp 3.
// RL6: With back-EMF sensing on, codes 100b and 111b route back-EMF amplifier.
// RL7: Register six decodes at 0x12 and resets to 0x40.
// RL8: Bit 6 of register six picks calibration data or factory trim.
// RL9: Finished back-EMF offset calibration clears the offset source bit.
// RL10: Bit 0 of register six puts gate driver logic in override.
// RL11: Controller reset releases enable pin; pulldown forces driver sleep.
// RL12: A dropped write leaves register six unchanged; reads still work.
package scl_pkg;
  localparam logic [7:0] SCL_ADDR_FIVE  = 8'h11;
  localparam logic [7:0] SCL_ADDR_SIX   = 8'h12;
  localparam logic [7:0] SCL_RST_FIVE   = 8'h00;
  localparam logic [7:0] SCL_RST_SIX    = 8'h40;
  localparam logic [7:0] SCL_MASK_FIVE  = 8'hA7;
  localparam logic [7:0] SCL_MASK_SIX   = 8'h41;
  localparam int         SCL_BIT_ADT    = 7;
  localparam int         SCL_BIT_UNLOCK = 5;
  localparam int         SCL_BIT_OFFSET = 6;
  localparam int         SCL_BIT_OVR    = 0;
  localparam logic [2:0] SCL_MUX_GND    = 3'h0;
  localparam logic [2:0] SCL_MUX_VM     = 3'h1;
  localparam logic [2:0] SCL_MUX_TEMP   = 3'h2;
  localparam logic [2:0] SCL_MUX_REF    = 3'h3;
  localparam logic [2:0] SCL_MUX_AMP_R  = 3'h4;
  localparam logic [2:0] SCL_MUX_AMP    = 3'h7;
  typedef enum logic [2:0] {
    SCL_ROUTE_GND  = 3'b000,
    SCL_ROUTE_VM   = 3'b001,
    SCL_ROUTE_TEMP = 3'b010,
    SCL_ROUTE_REF  = 3'b011,
    SCL_ROUTE_AMP3 = 3'b100,
    SCL_ROUTE_BEMF = 3'b101,
    SCL_ROUTE_OPEN = 3'b110
  } scl_route_e;
endpackage : scl_pkg

// ### hw/scl_reg8.sv
`timescale 1ns/1ps
module scl_reg8 #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] MASK    = 8'hFF
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       clr_en,
  input  wire logic [7:0] clr_mask,
  output logic      [7:0] q
);
  logic [7:0] q_nxt;
  assign q_nxt = (wr_en ? (wr_data & MASK) : q) & ~(clr_en ? clr_mask : 8'h00);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) q <= RST_VAL;
    else q <= q_nxt;
  end
endmodule : scl_reg8

// ### hw/scl_regs.sv
`timescale 1ns/1ps
module scl_regs
  import scl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       bemf_cal_done,
  input  wire logic       back_emf_sense_enable,
  input  wire logic       mcu_reset_n,
  input  wire logic       drv_enable_req,
  output logic      [7:0] reg_rdata,
  output logic            adaptive_deadtime_off,
  output logic            back_emf_offset_source,
  output logic            gate_driver_override_enable,
  output logic      [2:0] monitor_route,
  output logic            monitor_series_res,
  output logic            driver_enable_port_pin_out,
  output logic            driver_enable_port_pin_oe_n
);
  logic [7:0] five_q;
  logic [7:0] six_q;
  logic       hit_five;
  logic       hit_six;
  logic       wr_five;
  logic       wr_six;
  logic       unlocked;
  logic [2:0] sel;
  logic [2:0] route_nxt;
  logic       series_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] off_mask;

  assign hit_five = reg_addr == SCL_ADDR_FIVE;
  assign hit_six  = reg_addr == SCL_ADDR_SIX; // RL7
  assign unlocked = five_q[SCL_BIT_UNLOCK];
  assign wr_five  = reg_wr && hit_five;
  assign wr_six   = reg_wr && hit_six && unlocked; // RL3 RL12
  // Calibration end clears offset source; a same-cycle write loses to it
  assign off_mask = 8'h01 << SCL_BIT_OFFSET;

  scl_reg8 #(.RST_VAL(SCL_RST_FIVE), .MASK(SCL_MASK_FIVE)) u_five (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr_en    (wr_five),
    .wr_data  (reg_wdata),
    .clr_en   (1'b0),
    .clr_mask (8'h00),
    .q        (five_q)
  );

  scl_reg8 #(.RST_VAL(SCL_RST_SIX), .MASK(SCL_MASK_SIX)) u_six (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr_en    (wr_six),
    .wr_data  (reg_wdata),
    .clr_en   (bemf_cal_done), // RL9
    .clr_mask (off_mask),
    .q        (six_q)
  );

  assign sel = five_q[2:0];
  always_comb begin
    route_nxt  = SCL_ROUTE_OPEN;
    series_nxt = 1'b0;
    unique case (sel) // RL5
      SCL_MUX_GND:   route_nxt = SCL_ROUTE_GND;
      SCL_MUX_VM:    route_nxt = SCL_ROUTE_VM;
      SCL_MUX_TEMP:  route_nxt = SCL_ROUTE_TEMP;
      SCL_MUX_REF:   route_nxt = SCL_ROUTE_REF;
      SCL_MUX_AMP_R: begin
        route_nxt  = back_emf_sense_enable ? SCL_ROUTE_BEMF : SCL_ROUTE_AMP3; // RL6
        series_nxt = 1'b1;
      end
      SCL_MUX_AMP:   route_nxt = back_emf_sense_enable ? SCL_ROUTE_BEMF : SCL_ROUTE_AMP3; // RL6
      default:       route_nxt = SCL_ROUTE_OPEN;
    endcase
  end

  assign rdata_nxt = !reg_rd ? reg_rdata : hit_five ? five_q : hit_six ? six_q : 8'h00; // RL12

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata                   <= 8'h00;
      adaptive_deadtime_off       <= 1'b0;
      back_emf_offset_source      <= 1'b1;
      gate_driver_override_enable <= 1'b0;
      monitor_route               <= SCL_ROUTE_GND;
      monitor_series_res          <= 1'b0;
      driver_enable_port_pin_out  <= 1'b0;
      driver_enable_port_pin_oe_n <= 1'b1;
    end else begin
      reg_rdata                   <= rdata_nxt;
      adaptive_deadtime_off       <= five_q[SCL_BIT_ADT]; // RL1
      back_emf_offset_source      <= six_q[SCL_BIT_OFFSET]; // RL8
      gate_driver_override_enable <= six_q[SCL_BIT_OVR]; // RL10
      monitor_route               <= route_nxt;
      monitor_series_res          <= series_nxt;
      driver_enable_port_pin_out  <= drv_enable_req & mcu_reset_n;
      driver_enable_port_pin_oe_n <= ~mcu_reset_n; // RL11
    end
  end

  a_locked_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && hit_six && !unlocked && !bemf_cal_done |=> $stable(six_q)) // RL3
    else $error("locked write changed register six");
  a_unlocked_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_wr && hit_six && unlocked && !bemf_cal_done |=> six_q == (($past(reg_wdata)) & SCL_MASK_SIX)) // RL12
    else $error("unlocked write not stored");
  a_cal_clear: assert property (@(posedge clk) disable iff (!rst_n)
    bemf_cal_done |=> !six_q[SCL_BIT_OFFSET] ##1 !back_emf_offset_source) // RL9
    else $error("offset source not cleared");
  a_deadtime_out: assert property (@(posedge clk) disable iff (!rst_n)
    wr_five |=> ##1 adaptive_deadtime_off == $past(reg_wdata[SCL_BIT_ADT], 2)) // RL1
    else $error("dead time control wrong");
  a_override_out: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 gate_driver_override_enable == $past(six_q[SCL_BIT_OVR])) // RL10
    else $error("override output wrong");
  a_bemf_route: assert property (@(posedge clk) disable iff (!rst_n)
    (sel == SCL_MUX_AMP_R) && back_emf_sense_enable |=>
    monitor_route == SCL_ROUTE_BEMF && monitor_series_res) // RL6
    else $error("back-emf route wrong");
  a_gnd_route: assert property (@(posedge clk) disable iff (!rst_n)
    sel == SCL_MUX_GND |=> monitor_route == SCL_ROUTE_GND) // RL5
    else $error("ground route wrong");
  a_pin_release: assert property (@(posedge clk) disable iff (!rst_n)
    !mcu_reset_n |=> driver_enable_port_pin_oe_n && !driver_enable_port_pin_out) // RL11
    else $error("enable pin not released");
  a_offset_src: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 back_emf_offset_source == $past(six_q[SCL_BIT_OFFSET])) // RL8
    else $error("offset source output wrong");
endmodule : scl_regs

// ### tb/scl_mcu.sv
`timescale 1ns/1ps
module scl_mcu (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clk);
    {reg_wr, reg_wdata} = {1'b0, ~d};
  endtask : wr
  task wr6(input logic [7:0] d, input logic [2:0] sel);
    wr(8'h11, {5'h04, sel});
    wr(8'h12, d);
    wr(8'h11, {5'h00, sel});
  endtask : wr6
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clk);
    d = reg_rdata;
    reg_rd = 1'b0;
  endtask : rd
endmodule : scl_mcu

// ### tb/tb_scl_regs.sv
`timescale 1ns/1ps
module tb_scl_regs
  import scl_pkg::*;
;
  logic       clk    = 1'b0;
  logic       rst_n  = 1'b0;
  logic       cal    = 1'b0;
  logic       bemf   = 1'b0;
  logic       mrst_n = 1'b1;
  logic       en_req = 1'b0;
  logic       wr, rd, adt, ofs, ovr, ser, pout, poe_n;
  logic [7:0] addr, wdata, rdata, v;
  logic [2:0] route;
  int         n_errors = 0;
  int         n_checks = 0;
  scl_regs dut (.clk(clk), .rst_n(rst_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .bemf_cal_done(cal), .back_emf_sense_enable(bemf),
    .mcu_reset_n(mrst_n), .drv_enable_req(en_req), .reg_rdata(rdata),
    .adaptive_deadtime_off(adt), .back_emf_offset_source(ofs),
    .gate_driver_override_enable(ovr), .monitor_route(route), .monitor_series_res(ser),
    .driver_enable_port_pin_out(pout), .driver_enable_port_pin_oe_n(poe_n));
  scl_mcu mcu (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata));
  initial forever #2 clk = ~clk;
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task t_lock;
    mcu.rd(SCL_ADDR_SIX, v);
    chk(v, 8'h40);
    chk(ofs, 8'h01);
    mcu.wr(SCL_ADDR_SIX, 8'h01);
    mcu.rd(SCL_ADDR_SIX, v);
    chk(v, 8'h40);
    chk(ovr, 8'h00);
    mcu.wr6(8'h41, 3'h0);
    mcu.rd(SCL_ADDR_SIX, v);
    chk(v, 8'h41);
    chk(ovr, 8'h01);
  endtask : t_lock
  task t_cal;
    @(negedge clk);
    cal = 1'b1;
    @(negedge clk);
    cal = 1'b0;
    @(negedge clk);
    chk(ofs, 8'h00);
    mcu.rd(SCL_ADDR_SIX, v);
    chk(v, 8'h01);
  endtask : t_cal
  task t_adt;
    mcu.wr(SCL_ADDR_FIVE, 8'h80);
    @(negedge clk);
    chk(adt, 8'h01);
    mcu.wr(SCL_ADDR_FIVE, 8'h00);
    @(negedge clk);
    chk(adt, 8'h00);
  endtask : t_adt
  task t_mux;
    logic [2:0] e;
    for (int b = 0; b < 2; b++) begin
      bemf = b[0];
      for (int c = 0; c < 8; c++) begin
        mcu.wr(SCL_ADDR_FIVE, {5'h00, c[2:0]});
        @(negedge clk);
        e = (c == 5 || c == 6) ? 3'h6 : (c >= 4) ? (b ? 3'h5 : 3'h4) : c[2:0];
        chk(route, e);
        chk(ser, c == 4);
      end
    end
  endtask : t_mux
  task t_pin;
    en_req = 1'b1;
    repeat (2) @(negedge clk);
    chk({pout, poe_n}, 8'h02);
    mrst_n = 1'b0;
    @(negedge clk);
    chk({pout, poe_n}, 8'h01);
  endtask : t_pin
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_lock;
    t_cal;
    t_adt;
    t_mux;
    t_pin;
    end_sim;
  end
  initial begin
    // Whole run needs well under 200 cycles
    #4000;
    n_errors++;
    end_sim;
  end
endmodule : tb_scl_regs
